/* src/sncb_consts.svh */
// Register numbers, field positions, reset values and timing constants of the node bank
`ifndef SNCB_CONSTS_SVH
`define SNCB_CONSTS_SVH
`define SNCB_REG_IDENT        8'h00
`define SNCB_REG_TOPO         8'h01
`define SNCB_REG_LOCKCFG      8'h04
`define SNCB_REG_NODE         8'h05
`define SNCB_REG_PLL          8'h06
`define SNCB_REG_SWDIV        8'h07
`define SNCB_REG_REFDIV       8'h08
`define SNCB_REG_DEVCODE      8'h09
`define SNCB_REG_USERCODE     8'h0A
`define SNCB_REG_ROUTE_LO     8'h0C
`define SNCB_REG_ROUTE_HI     8'h0D
`define SNCB_REG_SPARE        8'h10
`define SNCB_LOCK_SPACE_BIT   31
`define SNCB_LOCK_PLL_BIT     8
`define SNCB_HDR_BIT          0
`define SNCB_PLL_NORST_BIT    31
`define SNCB_PLL_NOWAIT_BIT   30
`define SNCB_PLL_BYPASS_BIT   29
`define SNCB_PLL_JTAGBOOT_BIT 28
`define SNCB_PLL_P_HI         25
`define SNCB_PLL_P_LO         23
`define SNCB_PLL_M_HI         20
`define SNCB_PLL_M_LO         8
`define SNCB_PLL_N_HI         6
`define SNCB_PLL_N_LO         0
`define SNCB_PLL_WR_MASK      32'hF3F9FF7F
`define SNCB_PLL_RESET        32'h00000000
`define SNCB_SWDIV_RESET      16'h0000
`define SNCB_REFDIV_RESET     16'h0003
`define SNCB_SPARE_MASK       32'h00000003
`define SNCB_TILE_RST_NS      100
`define SNCB_TILE_RST_CYC     ((`SNCB_TILE_RST_NS + 9) / 10)
`endif

/* src/sncb_pkg.sv */
// Types shared by the node configuration bank
package sncb_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  reg_num;
    logic [31:0] wdata;
  } sncb_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } sncb_cfg_rsp_t;

  typedef struct packed {
    logic [15:0] dest;
    logic        valid;
  } sncb_route_req_t;

  typedef struct packed {
    logic        valid;
    logic        local_hit;
    logic [3:0]  direction;
    logic [3:0]  dimension;
  } sncb_route_rsp_t;

  typedef struct packed {
    logic        boot_latched;
    logic [7:0]  boot_pins;
    logic        lock_space;
    logic        lock_pll;
    logic        one_byte_hdr;
    logic [15:0] node_id;
    logic [31:0] pll_word;
    logic [15:0] sw_div;
    logic [15:0] ref_div;
    logic [31:0] route_lo;
    logic [31:0] route_hi;
    logic [1:0]  spare;
    logic [7:0]  rst_cnt;
    logic        pll_apply;
    sncb_cfg_rsp_t   rsp;
    sncb_route_rsp_t route;
  } sncb_state_t;
endpackage

/* src/sncb_switch_node_config_bank.sv */
// Node configuration register bank with packet direction lookup
`timescale 1ns/100ps
`include "sncb_consts.svh"
module sncb_switch_node_config_bank #(
  parameter logic [7:0]  SWITCH_REVISION = 8'h01,
  parameter logic [7:0]  SWITCH_VERSION  = 8'h01,
  parameter logic [7:0]  NUM_LINKS       = 8'h08,
  parameter logic [7:0]  NUM_SW_PROCS    = 8'h02,
  parameter logic [7:0]  NUM_DEV_PROCS   = 8'h02,
  // Arbitrary neutral identity values
  parameter logic [31:0] DEVICE_CODE     = 32'h00000001,
  parameter logic [17:0] METAL_ID        = 18'h00001
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  input  wire logic [7:0]               boot_select_pins,
  input  wire logic [13:0]              otp_user_code,
  input  wire sncb_pkg::sncb_cfg_req_t  cfg_req,
  output sncb_pkg::sncb_cfg_rsp_t       cfg_rsp,
  input  wire sncb_pkg::sncb_route_req_t route_req,
  output sncb_pkg::sncb_route_rsp_t     route_rsp,
  output logic                          one_byte_headers,
  output logic [15:0]                   node_id,
  output logic [2:0]                    pll_p,
  output logic [12:0]                   pll_m,
  output logic [6:0]                    pll_n,
  output logic                          pll_bypass,
  output logic                          boot_from_jtag,
  output logic                          pll_skip_relock,
  output logic                          pll_apply,
  output logic                          tile_reset,
  output logic [15:0]                   switch_clk_ratio,
  output logic [15:0]                   ref_clk_ratio
);
  import sncb_pkg::*;

  localparam logic [7:0] TILE_RST_CYC = 8'(`SNCB_TILE_RST_CYC);

  sncb_state_t state;
  sncb_state_t next_state;
  logic [7:0]  boot_sync1;
  logic [7:0]  boot_sync2;
  logic [13:0] code_sync1;
  logic [13:0] code_sync2;

  // Pins are asynchronous to the core clock
  // No reset here, so the chain is full when reset lets go and the boot latch sees real pins
  always_ff @(posedge core_clk) begin
    boot_sync1 <= boot_select_pins;
    boot_sync2 <= boot_sync1;
    code_sync1 <= otp_user_code;
    code_sync2 <= code_sync1;
  end

  function automatic logic [31:0] read_word(input sncb_state_t s, input logic [7:0] num,
                                            input logic [13:0] ucode);
    logic [31:0] w;
    w = 32'h00000000;
    unique case (num)
      `SNCB_REG_IDENT:    w = {8'h00, s.boot_pins, SWITCH_REVISION, SWITCH_VERSION};
      `SNCB_REG_TOPO:     w = {8'h00, NUM_LINKS, NUM_SW_PROCS, NUM_DEV_PROCS};
      `SNCB_REG_LOCKCFG: begin
        w[`SNCB_LOCK_SPACE_BIT] = s.lock_space;
        w[`SNCB_LOCK_PLL_BIT]   = s.lock_pll;
        w[`SNCB_HDR_BIT]        = s.one_byte_hdr;
      end
      `SNCB_REG_NODE:     w = {16'h0000, s.node_id};
      `SNCB_REG_PLL:      w = s.pll_word;
      `SNCB_REG_SWDIV:    w = {16'h0000, s.sw_div};
      `SNCB_REG_REFDIV:   w = {16'h0000, s.ref_div};
      `SNCB_REG_DEVCODE:  w = DEVICE_CODE;
      `SNCB_REG_USERCODE: w = {ucode, METAL_ID};
      `SNCB_REG_ROUTE_LO: w = s.route_lo;
      `SNCB_REG_ROUTE_HI: w = s.route_hi;
      `SNCB_REG_SPARE:    w = {30'h0, s.spare};
      default:            w = 32'h00000000;
    endcase
    return w;
  endfunction

  always_comb begin
    logic [15:0] diff;
    logic [3:0]  dim;
    logic [31:0] tbl;
    logic        wr;
    diff = 16'h0000;
    dim  = 4'h0;
    tbl  = 32'h00000000;
    wr   = 1'b0;
    next_state = state;
    next_state.rsp.valid   = 1'b0;
    next_state.route.valid = 1'b0;
    next_state.pll_apply   = 1'b0;

    // Boot pins are caught once, after release of reset
    if (!state.boot_latched) begin
      next_state.boot_latched = 1'b1;
      next_state.boot_pins    = boot_sync2;
    end

    if (state.rst_cnt != 8'h00) begin
      next_state.rst_cnt = state.rst_cnt - 8'h01;
    end

    if (cfg_req.valid) begin
      next_state.rsp.valid = 1'b1;
      next_state.rsp.rdata = read_word(state, cfg_req.reg_num, code_sync2);
      // A locked space drops the whole write, lock register included
      wr = cfg_req.write && !state.lock_space;
      if (wr) begin
        unique case (cfg_req.reg_num)
          `SNCB_REG_LOCKCFG: begin
            next_state.lock_space   = cfg_req.wdata[`SNCB_LOCK_SPACE_BIT];
            next_state.lock_pll     = cfg_req.wdata[`SNCB_LOCK_PLL_BIT];
            next_state.one_byte_hdr = cfg_req.wdata[`SNCB_HDR_BIT];
          end
          `SNCB_REG_NODE:     next_state.node_id = cfg_req.wdata[15:0];
          `SNCB_REG_PLL: begin
            if (!state.lock_pll) begin
              next_state.pll_word  = cfg_req.wdata & `SNCB_PLL_WR_MASK;
              next_state.pll_apply = 1'b1;
              if (!cfg_req.wdata[`SNCB_PLL_NORST_BIT]) begin
                next_state.rst_cnt = TILE_RST_CYC;
              end
            end
          end
          `SNCB_REG_SWDIV:    next_state.sw_div   = cfg_req.wdata[15:0];
          `SNCB_REG_REFDIV:   next_state.ref_div  = cfg_req.wdata[15:0];
          `SNCB_REG_ROUTE_LO: next_state.route_lo = cfg_req.wdata;
          `SNCB_REG_ROUTE_HI: next_state.route_hi = cfg_req.wdata;
          `SNCB_REG_SPARE:    next_state.spare    = cfg_req.wdata[1:0];
          default: begin
          end
        endcase
      end
    end

    // Scan from bit 0 upward; the last hit gives the highest mismatch
    diff = route_req.dest ^ state.node_id;
    for (int i = 0; i < 16; i++) begin
      if (diff[i]) begin
        dim = 4'(i);
      end
    end
    tbl = dim[3] ? state.route_hi : state.route_lo;
    if (route_req.valid) begin
      next_state.route.valid     = 1'b1;
      next_state.route.dimension = dim;
      next_state.route.local_hit = (diff == 16'h0000);
      next_state.route.direction = (diff == 16'h0000) ? 4'h0 : tbl[{dim[2:0], 2'b00} +: 4];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state              <= '0;
      state.pll_word     <= `SNCB_PLL_RESET;
      state.sw_div       <= `SNCB_SWDIV_RESET;
      state.ref_div      <= `SNCB_REFDIV_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign cfg_rsp          = state.rsp;
  assign route_rsp        = state.route;
  assign one_byte_headers = state.one_byte_hdr;
  assign node_id          = state.node_id;
  assign pll_p            = state.pll_word[`SNCB_PLL_P_HI:`SNCB_PLL_P_LO];
  assign pll_m            = state.pll_word[`SNCB_PLL_M_HI:`SNCB_PLL_M_LO];
  assign pll_n            = state.pll_word[`SNCB_PLL_N_HI:`SNCB_PLL_N_LO];
  assign pll_bypass       = state.pll_word[`SNCB_PLL_BYPASS_BIT];
  assign boot_from_jtag   = state.pll_word[`SNCB_PLL_JTAGBOOT_BIT];
  // Only safe for gradual PLL changes; software owns that judgement
  assign pll_skip_relock  = state.pll_word[`SNCB_PLL_NOWAIT_BIT];
  assign pll_apply        = state.pll_apply;
  assign tile_reset       = (state.rst_cnt != 8'h00);
  assign switch_clk_ratio = state.sw_div;
  assign ref_clk_ratio    = state.ref_div;
endmodule

/* test/sncb_cfg_host.sv */
// Host model issuing numbered configuration reads and writes
`timescale 1ns/100ps
module sncb_cfg_host (
  input  wire logic                    core_clk,
  output sncb_pkg::sncb_cfg_req_t      cfg_req,
  input  wire sncb_pkg::sncb_cfg_rsp_t cfg_rsp
);
  import sncb_pkg::*;
  initial cfg_req = '0;
  // One-cycle pulse; an edge always passes between two accesses
  task automatic access(input logic wr, input logic [7:0] num, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ok);
    @(negedge core_clk);
    cfg_req = '{valid: 1'b1, write: wr, reg_num: num, wdata: wd};
    @(negedge core_clk);
    cfg_req.valid = 1'b0;
    rd = cfg_rsp.rdata;
    ok = cfg_rsp.valid;
  endtask
endmodule

/* test/sncb_switch_node_config_bank_properties.sv */
// Port-level checks for the node configuration bank
`timescale 1ns/100ps
module sncb_bank_checker (
  input wire logic                     core_clk,
  input wire logic                     rst_n,
  input wire sncb_pkg::sncb_cfg_req_t   cfg_req,
  input wire sncb_pkg::sncb_cfg_rsp_t   cfg_rsp,
  input wire sncb_pkg::sncb_route_req_t route_req,
  input wire sncb_pkg::sncb_route_rsp_t route_rsp,
  input wire logic                     one_byte_headers,
  input wire logic [15:0]              node_id,
  input wire logic [2:0]               pll_p,
  input wire logic [12:0]              pll_m,
  input wire logic [6:0]               pll_n,
  input wire logic                     pll_bypass,
  input wire logic                     boot_from_jtag,
  input wire logic                     pll_skip_relock,
  input wire logic                     pll_apply,
  input wire logic                     tile_reset
);
  import sncb_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Ten cycles high, then low
  sequence rst_run_s;
    tile_reset [*8] ##1 tile_reset ##1 tile_reset ##1 !tile_reset;
  endsequence
  AST_RSP_ONE: assert property (cfg_rsp.valid == $past(cfg_req.valid))
    else $error("config answer not one cycle after request");
  AST_APPLY_CAUSE: assert property (pll_apply |-> $past(cfg_req.valid && cfg_req.write)
    && $past(cfg_req.reg_num) == 8'h06) else $error("pll apply without pll write");
  AST_TILE_CAUSE: assert property ($rose(tile_reset) |-> pll_apply
    && !$past(cfg_req.wdata[31])) else $error("tile reset without reset-enabled write");
  AST_TILE_LEN: assert property ($rose(tile_reset) |-> rst_run_s)
    else $error("tile reset length wrong");
  AST_PLL_DIV: assert property (pll_apply |-> {pll_p, pll_m, pll_n} ==
    {$past(cfg_req.wdata[25:23]), $past(cfg_req.wdata[20:8]), $past(cfg_req.wdata[6:0])})
    else $error("pll dividers not taken from write");
  AST_PLL_MODE: assert property (pll_apply |->
    {pll_skip_relock, pll_bypass, boot_from_jtag} == $past(cfg_req.wdata[30:28]))
    else $error("pll mode bits not taken from write");
  AST_NODE_WR: assert property ($changed(node_id) |-> $past(cfg_req.valid &&
    cfg_req.write) && $past(cfg_req.reg_num) == 8'h05) else $error("node id changed alone");
  AST_HDR_WR: assert property ($changed(one_byte_headers) |-> $past(cfg_req.reg_num)
    == 8'h04 && one_byte_headers == $past(cfg_req.wdata[0])) else $error("header mode");
  AST_ROUTE: assert property (route_req.valid |=> route_rsp.valid &&
    route_rsp.local_hit == ($past(route_req.dest) == node_id)) else $error("route answer");
endmodule
bind sncb_switch_node_config_bank sncb_bank_checker i_sncb_bank_checker (.core_clk, .rst_n,
  .cfg_req, .cfg_rsp, .route_req, .route_rsp, .one_byte_headers, .node_id, .pll_p, .pll_m,
  .pll_n, .pll_bypass, .boot_from_jtag, .pll_skip_relock, .pll_apply, .tile_reset);

/* test/sncb_switch_node_config_bank_tb_top.sv */
// Self-checking bench for the node configuration bank
`timescale 1ns/100ps
module sncb_switch_node_config_bank_tb_top;
  import sncb_pkg::*;
  logic            core_clk, rst_n, ok;
  logic [7:0]      boot_select_pins;
  logic [13:0]     otp_user_code;
  sncb_cfg_req_t   cfg_req;
  sncb_cfg_rsp_t   cfg_rsp;
  sncb_route_req_t route_req;
  sncb_route_rsp_t route_rsp;
  logic            one_byte_headers, pll_bypass, boot_from_jtag, pll_skip_relock;
  logic            pll_apply, tile_reset;
  logic [15:0]     node_id, switch_clk_ratio, ref_clk_ratio;
  logic [2:0]      pll_p;
  logic [12:0]     pll_m;
  logic [6:0]      pll_n;
  logic [31:0]     rd;
  int              errors = 0, samples_checked = 0, cycles = 0, n;
  logic [7:0]  rn [13] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                           8'h0A, 8'h0C, 8'h0D, 8'h10};
  logic [31:0] rv [13] = '{32'h00A50101, 32'h00080202, 0, 0, 0, 0, 0, 32'h3, 32'h1,
                           32'hB52C0001, 0, 0, 0};
  logic [7:0]  wn [7] = '{8'h05, 8'h07, 8'h08, 8'h0C, 8'h0D, 8'h10, 8'h00};
  logic [31:0] wd [7] = '{'1, '1, '1, 32'h12345678, 32'h9ABCDEF0, '1, '1};
  logic [31:0] we [7] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h12345678, 32'h9ABCDEF0, 32'h3,
                          32'h00A50101};
  sncb_switch_node_config_bank i_sncb_switch_node_config_bank (.core_clk, .rst_n,
    .boot_select_pins, .otp_user_code, .cfg_req, .cfg_rsp, .route_req, .route_rsp,
    .one_byte_headers, .node_id, .pll_p, .pll_m, .pll_n, .pll_bypass, .boot_from_jtag,
    .pll_skip_relock, .pll_apply, .tile_reset, .switch_clk_ratio, .ref_clk_ratio);
  sncb_cfg_host i_sncb_cfg_host (.core_clk, .cfg_req, .cfg_rsp);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_sncb_cfg_host.access(w, a, d, rd, ok);
    chk({31'h0, ok}, 32'h1);
  endtask
  // Expected is {local, direction, dimension}
  task automatic rt(input logic [15:0] d, input logic [8:0] exp);
    @(negedge core_clk);
    route_req = '{dest: d, valid: 1'b1};
    @(negedge core_clk);
    route_req.valid = 1'b0;
    chk({22'h0, route_rsp.valid, route_rsp.local_hit, route_rsp.direction,
         route_rsp.dimension}, {22'h0, 1'b1, exp});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    rst_n = 1'b0;
    boot_select_pins = 8'hA5;
    otp_user_code = 14'h2D4B;
    route_req = '0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk) rst_n = 1'b1;
    for (int i = 0; i < 13; i++) begin
      rw(1'b0, rn[i], 32'h0);
      chk(rd, rv[i]);
    end
    $display("test reset values done");
    for (int i = 0; i < 7; i++) begin
      rw(1'b1, wn[i], wd[i]);
      rw(1'b0, wn[i], 32'h0);
      chk(rd, we[i]);
    end
    chk({ref_clk_ratio, switch_clk_ratio}, '1);
    $display("test read write done");
    rw(1'b1, 8'h05, 32'h8001);
    rt(16'h8001, 9'h100);
    rt(16'h8000, 9'h080);
    rt(16'h8081, 9'h017);
    rt(16'h0001, 9'h09F);
    rt(16'h8101, 9'h008);
    $display("test routing done");
    rw(1'b1, 8'h06, 32'h7281A545);
    chk({pll_skip_relock, pll_bypass, boot_from_jtag, pll_p, pll_m, pll_n, tile_reset,
         pll_apply, 4'h0}, {3'h7, 3'h5, 13'h1A5, 7'h45, 1'b1, 1'b1, 4'h0});
    n = 0;
    while (tile_reset === 1'b1 && n < 20) begin
      n++;
      @(negedge core_clk);
    end
    chk(n, 10);
    rw(1'b1, 8'h06, 32'h80000000);
    chk({31'h0, tile_reset}, 32'h0);
    $display("test pll done");
    rw(1'b1, 8'h04, 32'h00000101);
    chk({31'h0, one_byte_headers}, 32'h1);
    rw(1'b1, 8'h06, 32'h00000001);
    chk({31'h0, tile_reset}, 32'h0);
    rw(1'b0, 8'h06, 32'h0);
    chk(rd, 32'h80000000);
    rw(1'b1, 8'h04, '1);
    rw(1'b1, 8'h05, 32'h1234);
    chk({16'h0, node_id}, 32'h8001);
    rw(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h80000101);
    $display("test locks done");
    complete_run();
  end
endmodule
